/* include/sabd_pkg.sv */
// package for the sdram command and address decode block
// assumes a single clock shared with the controller that drives the pins
`default_nettype none
package sabd_pkg;

  // ==========================================================================
  // command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SABD_CODE_LOAD_MODE  = 4'h0;
  localparam logic [3:0] SABD_CODE_REFRESH    = 4'h1;
  localparam logic [3:0] SABD_CODE_PRECHARGE  = 4'h2;
  localparam logic [3:0] SABD_CODE_ACTIVE     = 4'h3;
  localparam logic [3:0] SABD_CODE_WRITE      = 4'h4;
  localparam logic [3:0] SABD_CODE_READ       = 4'h5;
  localparam logic [3:0] SABD_CODE_BURST_STOP = 4'h6;
  localparam logic [3:0] SABD_CODE_NOP        = 4'h7;

  // ==========================================================================
  // field positions and widths
  localparam int SABD_BANK_W       = 2;
  localparam int SABD_NBANK        = 4;
  localparam int SABD_ADDR_W       = 12;
  localparam int SABD_COL_MAX_W    = 10;
  localparam int SABD_PRE_SCOPE    = 10;
  localparam int SABD_DQ_MAX_W     = 16;
  localparam int SABD_LANES        = 2;
  localparam int SABD_COL_W_X4     = 10;
  localparam int SABD_COL_W_X8     = 9;
  localparam int SABD_COL_W_X16    = 8;
  localparam int SABD_DQ_W_X16     = 16;
  localparam int SABD_MASK_LATENCY = 2;

  // ==========================================================================
  // values after reset
  localparam logic [3:0]  SABD_PRE_RST  = 4'h0;
  localparam logic [11:0] SABD_ADDR_RST = 12'h000;
  localparam logic [15:0] SABD_DQ_RST   = 16'h0000;
  localparam logic [1:0]  SABD_BE_RST   = 2'h0;

  typedef enum logic [3:0] {
    SABD_NOP,
    SABD_ACTIVE,
    SABD_READ,
    SABD_WRITE,
    SABD_PRECHARGE,
    SABD_LOAD_MODE,
    SABD_REFRESH,
    SABD_BURST_STOP,
    SABD_INHIBIT
  } sabd_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sabd_pins_t;

  typedef struct packed {
    logic [SABD_BANK_W-1:0]    bank;
    logic [SABD_ADDR_W-1:0]    row;
    logic [SABD_COL_MAX_W-1:0] col;
    logic                      precharge_scope_bit;
    logic [SABD_NBANK-1:0]     pre_banks;
  } sabd_decode_t;

endpackage : sabd_pkg
`default_nettype wire

/* verilog/sabd_delay_pipe.sv */
// fixed-depth delay line with registered output
// assumes synchronous active-high reset on the same clock as its user
`default_nettype none
module sabd_delay_pipe
  import sabd_pkg::*;
#(
  parameter int W     = 2,
  parameter int DEPTH = 2
)(
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data
);

  logic [W-1:0] stage_q [DEPTH];

  // ==========================================================================
  // stages
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int k = 0; k < DEPTH; k++)
        stage_q[k] <= '0;
    end
    else
    begin
      stage_q[0] <= i_data;
      for (int k = 1; k < DEPTH; k++)
        stage_q[k] <= stage_q[k-1];
    end
  end

  assign o_data = stage_q[DEPTH-1];

endmodule : sabd_delay_pipe
`default_nettype wire

/* verilog/sabd_decode.sv */
// device-side decode of sdram command, bank, address and data mask pins
// assumes the controller drives every pin from the same rising clock edge
`default_nettype none

// What this block does
// RULE1: bank inputs select target bank per command
// RULE2: active captures all twelve address bits as row
// RULE3: column width ten, nine, eight by variant
// RULE4: address bit ten requests auto precharge
// RULE5: precharge bit ten high means all banks
// RULE6: load mode takes op-code from address
// RULE7: data bus width follows variant, rest unused
// RULE8: every input sampled on rising clock edge
// RULE9: command decoded from four low-active lines
// RULE10: chip select high masks commands, not masks
// RULE11: mask blocks writes, read high-z after two
module sabd_decode
  import sabd_pkg::*;
#(
  parameter int DQ_W = 16
)(
  input  wire logic                       i_clock,
  input  wire logic                       i_srst,
  input  wire sabd_pins_t                 i_cmd,
  input  wire logic [SABD_BANK_W-1:0]     i_bank,
  input  wire logic [SABD_ADDR_W-1:0]     i_addr,
  input  wire logic                       i_low_byte_mask,
  input  wire logic                       i_high_byte_mask,
  input  wire logic [SABD_DQ_MAX_W-1:0]   i_dq,
  input  wire logic                       i_wr_active,
  input  wire logic [SABD_DQ_MAX_W-1:0]   i_rd_data,
  input  wire logic                       i_rd_valid,
  output sabd_cmd_t                       o_cmd,
  output logic                            o_cmd_valid,
  output sabd_decode_t                    o_decode,
  output logic [SABD_ADDR_W-1:0]          o_mode_opcode,
  output logic                            o_mode_load,
  output logic [SABD_DQ_MAX_W-1:0]        o_wr_data,
  output logic [SABD_LANES-1:0]           o_wr_byte_en,
  output logic                            o_wr_valid,
  output logic [SABD_DQ_MAX_W-1:0]        o_dq,
  output logic [SABD_DQ_MAX_W-1:0]        o_dq_oe
);

  // ==========================================================================
  // variant geometry
  localparam int COL_W = (DQ_W == SABD_DQ_W_X16) ? SABD_COL_W_X16 :
                         (DQ_W == 8) ? SABD_COL_W_X8 : SABD_COL_W_X4;
  localparam logic [SABD_COL_MAX_W-1:0] COL_MASK =
    SABD_COL_MAX_W'((32'h1 << COL_W) - 32'h1);
  // lines above the variant width are never driven nor read
  localparam logic [SABD_DQ_MAX_W-1:0] USED_BITS =
    SABD_DQ_MAX_W'((32'h1 << DQ_W) - 32'h1);

  // ==========================================================================
  // command decode
  wire logic [3:0] code_w = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n,
                             i_cmd.we_n};
  wire sabd_cmd_t  cmd_w =
    i_cmd.cs_n                        ? SABD_INHIBIT    : // RULE10
    (code_w == SABD_CODE_ACTIVE)      ? SABD_ACTIVE     : // RULE9
    (code_w == SABD_CODE_READ)        ? SABD_READ       :
    (code_w == SABD_CODE_WRITE)       ? SABD_WRITE      :
    (code_w == SABD_CODE_PRECHARGE)   ? SABD_PRECHARGE  :
    (code_w == SABD_CODE_LOAD_MODE)   ? SABD_LOAD_MODE  :
    (code_w == SABD_CODE_REFRESH)     ? SABD_REFRESH    :
    (code_w == SABD_CODE_BURST_STOP)  ? SABD_BURST_STOP : SABD_NOP;

  wire logic is_act_w  = (cmd_w == SABD_ACTIVE);
  wire logic is_rw_w   = (cmd_w == SABD_READ) || (cmd_w == SABD_WRITE);
  wire logic is_pre_w  = (cmd_w == SABD_PRECHARGE);
  wire logic is_lmr_w  = (cmd_w == SABD_LOAD_MODE);
  wire logic bank_up_w = is_act_w || is_rw_w || is_pre_w;
  wire logic scope_w   = i_addr[SABD_PRE_SCOPE];

  wire logic [SABD_NBANK-1:0] pre_banks_w =
    scope_w ? {SABD_NBANK{1'b1}} :                   // RULE5
              SABD_NBANK'(4'h1 << i_bank);
  wire logic [SABD_COL_MAX_W-1:0] col_w =
    i_addr[SABD_COL_MAX_W-1:0] & COL_MASK;           // RULE3

  // ==========================================================================
  // data mask lanes; narrow variants use the high mask as their only mask
  wire logic [SABD_LANES-1:0] lane_mask_w =
    {i_high_byte_mask,
     (DQ_W == SABD_DQ_W_X16) ? i_low_byte_mask : i_high_byte_mask};
  logic [SABD_LANES-1:0] lane_mask_d2;
  wire logic [SABD_DQ_MAX_W-1:0] wr_keep_w =
    {{8{~lane_mask_w[1]}}, {8{~lane_mask_w[0]}}} & USED_BITS;
  wire logic [SABD_DQ_MAX_W-1:0] rd_keep_w =
    {{8{~lane_mask_d2[1]}}, {8{~lane_mask_d2[0]}}} & USED_BITS;

  // masks act regardless of chip select
  sabd_delay_pipe #(
    .W     (SABD_LANES),
    .DEPTH (SABD_MASK_LATENCY)
  ) u_mask_pipe (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_data  (lane_mask_w),
    .o_data  (lane_mask_d2)
  );

  // ==========================================================================
  // sampled command and address fields
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_cmd       <= SABD_NOP;
      o_cmd_valid <= 1'b0;
      o_mode_load <= 1'b0;
    end
    else
    begin
      o_cmd       <= cmd_w;                          // RULE8
      o_cmd_valid <= !i_cmd.cs_n;                    // RULE10
      o_mode_load <= is_lmr_w;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_decode <= '0;
    else
    begin
      if (bank_up_w)
        o_decode.bank <= i_bank;                     // RULE1
      if (is_act_w)
        o_decode.row <= i_addr;                      // RULE2
      if (is_rw_w)
      begin
        o_decode.col                 <= col_w;
        o_decode.precharge_scope_bit <= scope_w;     // RULE4
      end
      if (is_pre_w)
        o_decode.pre_banks <= pre_banks_w;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_mode_opcode <= SABD_ADDR_RST;
    else if (is_lmr_w)
      o_mode_opcode <= i_addr;                       // RULE6
  end

  // ==========================================================================
  // write data capture with byte masking
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_wr_data    <= SABD_DQ_RST;
      o_wr_byte_en <= SABD_BE_RST;
      o_wr_valid   <= 1'b0;
    end
    else
    begin
      o_wr_data    <= i_dq & wr_keep_w;              // RULE11
      o_wr_byte_en <= ~lane_mask_w;
      o_wr_valid   <= i_wr_active;
    end
  end

  // ==========================================================================
  // read drive; enable falls two clocks after the mask is sampled
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_dq    <= SABD_DQ_RST;
      o_dq_oe <= SABD_DQ_RST;
    end
    else
    begin
      o_dq    <= i_rd_data & USED_BITS;              // RULE7
      o_dq_oe <= {SABD_DQ_MAX_W{i_rd_valid}} & rd_keep_w; // RULE11
    end
  end

  // ==========================================================================
  // checks
  AST_BANK: assert property (@(posedge i_clock) disable iff (i_srst) // RULE1
    !$past(i_srst) && $past(bank_up_w) |-> o_decode.bank == $past(i_bank))
    else $error("bank not taken from bank inputs");

  AST_ROW: assert property (@(posedge i_clock) disable iff (i_srst) // RULE2
    !$past(i_srst) && $past(is_act_w) |-> o_decode.row == $past(i_addr))
    else $error("row not captured");

  // the row must survive every other command, or a later access hits
  // the wrong page
  AST_HOLD: assert property (@(posedge i_clock) disable iff (i_srst) // RULE2
    !$past(i_srst) && !$past(is_act_w) |-> $stable(o_decode.row))
    else $error("row changed without active");

  AST_COL: assert property (@(posedge i_clock) disable iff (i_srst) // RULE3
    !$past(i_srst) && $past(is_rw_w) |->
      o_decode.col == ($past(i_addr[SABD_COL_MAX_W-1:0]) & COL_MASK))
    else $error("column width wrong for variant");

  AST_AUTO_PRE: assert property (@(posedge i_clock) // RULE4
    disable iff (i_srst)
    !$past(i_srst) && $past(is_rw_w) |->
      o_decode.precharge_scope_bit == $past(i_addr[SABD_PRE_SCOPE]))
    else $error("auto precharge flag not taken");

  AST_PRE_ALL: assert property (@(posedge i_clock) // RULE5
    disable iff (i_srst)
    !$past(i_srst) && $past(is_pre_w) |->
      (o_decode.pre_banks == 4'hf) == $past(scope_w) &&
      $onehot(o_decode.pre_banks) == !$past(scope_w))
    else $error("precharge scope wrong");

  AST_MODE: assert property (@(posedge i_clock) disable iff (i_srst) // RULE6
    o_mode_load |-> o_mode_opcode == $past(i_addr) && o_cmd == SABD_LOAD_MODE)
    else $error("mode op-code not loaded");

  AST_UNUSED: assert property (@(posedge i_clock) disable iff (i_srst) // RULE7
    (o_dq_oe & ~USED_BITS) == 16'h0000 && (o_dq & ~USED_BITS) == 16'h0000)
    else $error("unused data line driven");

  AST_DECODE: assert property (@(posedge i_clock) disable iff (i_srst) // RULE9
    !$past(i_srst) && $past(code_w) == SABD_CODE_READ |-> o_cmd == SABD_READ)
    else $error("read code misdecoded");

  AST_CS_HIGH: assert property (@(posedge i_clock) // RULE10
    disable iff (i_srst)
    !$past(i_srst) && $past(i_cmd.cs_n) |->
      !o_cmd_valid && !o_mode_load && $stable(o_decode))
    else $error("command taken with chip select high");

  // enable is registered at the second edge after the mask, so it is
  // sampled here one edge later still
  AST_RD_MASK: assert property (@(posedge i_clock) // RULE11
    disable iff (i_srst)
    !$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3) &&
      $past(i_high_byte_mask, 3) |-> o_dq_oe[15:8] == 8'h00)
    else $error("high lane driven two clocks after mask");

  AST_WR_MASK: assert property (@(posedge i_clock) // RULE11
    disable iff (i_srst)
    !$past(i_srst) && $past(i_high_byte_mask) |->
      !o_wr_byte_en[1] && o_wr_data[15:8] == 8'h00)
    else $error("masked write byte passed");

endmodule : sabd_decode
`default_nettype wire

/* tb/sabd_ctrl_model.sv */
// controller-side model driving command, bank and address pins
// assumes the bench calls its tasks just after a rising clock edge
`default_nettype none
module sabd_ctrl_model
  import sabd_pkg::*;
(
  input  wire logic                   i_clock,
  output var  sabd_pins_t             o_cmd,
  output var  logic [SABD_BANK_W-1:0] o_bank,
  output var  logic [SABD_ADDR_W-1:0] o_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_cmd  = sabd_pins_t'(SABD_CODE_NOP);
    o_bank = 2'h0;
    o_addr = 12'h000;
  end
  // ==========================================================================
  // command tasks
  // the pins stay put after a command so back-to-back sends are one cycle
  task automatic send(input logic [3:0] code, input logic [1:0] bank,
                      input logic [11:0] addr);
    o_cmd  = sabd_pins_t'(code);
    o_bank = bank;
    o_addr = addr;
    @(posedge i_clock);
    #1;
  endtask : send
  // released bank and address pins are scrambled so a stale value never passes by luck
  task automatic idle();
    o_cmd  = sabd_pins_t'(SABD_CODE_NOP);
    o_bank = ~o_bank;
    o_addr = ~o_addr;
  endtask : idle
endmodule : sabd_ctrl_model
`default_nettype wire

/* tb/sabd_decode_tb.sv */
// self-checking bench for the command and address decode block
// assumes the controller model file is compiled just before this one
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module sabd_decode_tb
  import sabd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 1'b0, i_srst = 1'b1, i_low_byte_mask = 1'b0;
  logic i_high_byte_mask = 1'b0, i_wr_active = 1'b0, i_rd_valid = 1'b0;
  logic [15:0] i_dq = 16'h0000, i_rd_data = 16'h0000, o_wr_data, o_dq, o_dq_oe;
  logic [11:0] o_mode_opcode, m_addr;
  logic [1:0]  o_wr_byte_en, m_bank;
  logic        o_cmd_valid, o_mode_load, o_wr_valid;
  sabd_pins_t  m_cmd;
  sabd_cmd_t   o_cmd;
  sabd_decode_t o_decode;
  logic [15:0]  o8_wr_data, o8_dq, o8_dq_oe;
  sabd_decode_t o8_decode;
  int n_errors = 0, n_tests = 0, cycles = 0;
  always #2 i_clock = ~i_clock;
  sabd_ctrl_model u_ctrl (.i_clock(i_clock), .o_cmd(m_cmd), .o_bank(m_bank),
    .o_addr(m_addr));
  sabd_decode #(.DQ_W(16)) dut (.i_clock(i_clock), .i_srst(i_srst),
    .i_cmd(m_cmd), .i_bank(m_bank), .i_addr(m_addr),
    .i_low_byte_mask(i_low_byte_mask), .i_high_byte_mask(i_high_byte_mask),
    .i_dq(i_dq), .i_wr_active(i_wr_active), .i_rd_data(i_rd_data),
    .i_rd_valid(i_rd_valid), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid),
    .o_decode(o_decode), .o_mode_opcode(o_mode_opcode),
    .o_mode_load(o_mode_load), .o_wr_data(o_wr_data),
    .o_wr_byte_en(o_wr_byte_en), .o_wr_valid(o_wr_valid), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe));
  // x8 variant on the same pins covers the narrower column and data bus
  sabd_decode #(.DQ_W(8)) dut_x8 (.i_clock(i_clock), .i_srst(i_srst),
    .i_cmd(m_cmd), .i_bank(m_bank), .i_addr(m_addr),
    .i_low_byte_mask(i_low_byte_mask), .i_high_byte_mask(i_high_byte_mask),
    .i_dq(i_dq), .i_wr_active(i_wr_active), .i_rd_data(i_rd_data),
    .i_rd_valid(i_rd_valid), .o_cmd(), .o_cmd_valid(),
    .o_decode(o8_decode), .o_mode_opcode(), .o_mode_load(),
    .o_wr_data(o8_wr_data), .o_wr_byte_en(), .o_wr_valid(), .o_dq(o8_dq),
    .o_dq_oe(o8_dq_oe));
  // ==========================================================================
  // scenarios
  task automatic t_codes();
    sabd_cmd_t exp [8];
    exp = '{SABD_LOAD_MODE, SABD_REFRESH, SABD_PRECHARGE, SABD_ACTIVE,
            SABD_WRITE, SABD_READ, SABD_BURST_STOP, SABD_NOP};
    for (int c = 0; c < 8; c++)
    begin
      u_ctrl.send(c[3:0], 2'h0, 12'h000);
      `CHK("cmd", exp[c], o_cmd)
      `CHK("cmd_valid", 1'b1, o_cmd_valid)
    end
    $display("test codes done");
  endtask : t_codes
  task automatic t_access();
    u_ctrl.send(SABD_CODE_ACTIVE, 2'h2, 12'habc);
    `CHK("bank", 2'h2, o_decode.bank)
    `CHK("row", 12'habc, o_decode.row)
    u_ctrl.send(SABD_CODE_READ, 2'h1, 12'h5ff);
    `CHK("col", 10'h0ff, o_decode.col)
    `CHK("col8", 10'h1ff, o8_decode.col)
    `CHK("ap", 1'b1, o_decode.precharge_scope_bit)
    `CHK("bank", 2'h1, o_decode.bank)
    u_ctrl.send(SABD_CODE_WRITE, 2'h3, 12'h3a5);
    `CHK("cmd", SABD_WRITE, o_cmd)
    `CHK("col", 10'h0a5, o_decode.col)
    `CHK("col8", 10'h1a5, o8_decode.col)
    `CHK("ap", 1'b0, o_decode.precharge_scope_bit)
    `CHK("row", 12'habc, o_decode.row)
    $display("test access done");
  endtask : t_access
  task automatic t_pre();
    u_ctrl.send(SABD_CODE_PRECHARGE, 2'h1, 12'h000);
    `CHK("pre", 4'h2, o_decode.pre_banks)
    u_ctrl.send(SABD_CODE_PRECHARGE, 2'h3, 12'h400);
    `CHK("pre", 4'hf, o_decode.pre_banks)
    u_ctrl.send(SABD_CODE_PRECHARGE, 2'h2, 12'hbff);
    `CHK("pre", 4'h4, o_decode.pre_banks)
    u_ctrl.send(SABD_CODE_LOAD_MODE, 2'h0, 12'h237);
    `CHK("mload", 1'b1, o_mode_load)
    `CHK("opcode", 12'h237, o_mode_opcode)
    u_ctrl.idle();
    @(posedge i_clock);
    #1;
    `CHK("mload", 1'b0, o_mode_load)
    $display("test precharge and mode done");
  endtask : t_pre
  task automatic t_inhibit();
    i_dq = 16'hbeef;
    i_high_byte_mask = 1'b1;
    i_wr_active = 1'b1;
    u_ctrl.send(4'hb, 2'h0, 12'h123);
    `CHK("cmd", SABD_INHIBIT, o_cmd)
    `CHK("cmd_valid", 1'b0, o_cmd_valid)
    `CHK("row", 12'habc, o_decode.row)
    `CHK("wdata", 16'h00ef, o_wr_data)
    `CHK("be", 2'h1, o_wr_byte_en)
    `CHK("wvalid", 1'b1, o_wr_valid)
    `CHK("wdata8", 16'h0000, o8_wr_data)
    i_high_byte_mask = 1'b0;
    i_low_byte_mask = 1'b1;
    i_dq = 16'h1234;
    u_ctrl.idle();
    @(posedge i_clock);
    #1;
    `CHK("wdata", 16'h1200, o_wr_data)
    `CHK("be", 2'h2, o_wr_byte_en)
    `CHK("wdata8", 16'h0034, o8_wr_data)
    `CHK("wvalid", 1'b1, o_wr_valid)
    i_low_byte_mask = 1'b0;
    i_wr_active = 1'b0;
    $display("test inhibit and write mask done");
  endtask : t_inhibit
  task automatic t_rdmask();
    i_high_byte_mask = 1'b1;
    i_rd_data = 16'h5a5a;
    @(posedge i_clock);
    #1;
    i_high_byte_mask = 1'b0;
    i_rd_valid = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    `CHK("oe", 16'h00ff, o_dq_oe)
    `CHK("oe8", 16'h0000, o8_dq_oe)
    @(posedge i_clock);
    #1;
    `CHK("oe", 16'hffff, o_dq_oe)
    `CHK("dq", 16'h5a5a, o_dq)
    `CHK("oe8", 16'h00ff, o8_dq_oe)
    `CHK("dq8", 16'h005a, o8_dq)
    i_rd_valid = 1'b0;
    $display("test read mask done");
  endtask : t_rdmask
  // ==========================================================================
  // run control
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    t_codes();
    t_access();
    t_pre();
    t_inhibit();
    t_rdmask();
    tally_and_finish();
  end
endmodule : sabd_decode_tb
`default_nettype wire
